// [dct_edge_det.sv]
// Event pin synchroniser and falling edge detector
`timescale 1ns/1ps
module dct_edge_det (
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    input wire logic i_pin,
    output logic o_fall
);
    import dct_pkg::*;

    logic sync1_reg;
    logic sync2_reg;
    dct_edge_t state_reg;
    dct_edge_t state_next;
    logic fall_next;

    // ****************************************
    // Two stage synchroniser
    // ****************************************
    // First stage is read only by the second
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else begin
            sync1_reg <= i_pin;
            sync2_reg <= sync1_reg;
        end
    end

    // Level tracker; idle until first sample so reset does not fake an edge
    always_comb begin
        state_next = state_reg;
        fall_next = 1'b0;
        case (state_reg)
            DCT_EDGE_IDLE: state_next = sync2_reg ? DCT_EDGE_HIGH : DCT_EDGE_LOW;
            DCT_EDGE_HIGH: begin
                if (!sync2_reg) begin
                    state_next = DCT_EDGE_LOW;
                    fall_next = 1'b1;
                end
            end
            DCT_EDGE_LOW: begin
                if (sync2_reg) begin
                    state_next = DCT_EDGE_HIGH;
                end
            end
            default: state_next = DCT_EDGE_IDLE;
        endcase
    end

    // One pulse per high-to-low transition
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_reg <= DCT_EDGE_IDLE;
            o_fall <= 1'b0;
        end else begin
            state_reg <= state_next;
            o_fall <= fall_next;
        end
    end
endmodule

// [dct_event_src.sv]
// Model of the event and gate pins outside the counter/timer
`timescale 1ns/1ps
module dct_event_src (
    input wire logic i_ref_clk,
    output logic [1:0] o_event_pin,
    output logic [1:0] o_ext_gate_n
);
    initial begin
        o_event_pin = 2'b11;
        o_ext_gate_n = 2'b11;
    end
    // Falls at a quarter of the clock, each level held two clocks
    task pulses(input int t, n);
        repeat (n) begin
            @(posedge i_ref_clk) #1 o_event_pin[t] = 0;
            @(posedge i_ref_clk);
            @(posedge i_ref_clk) #1 o_event_pin[t] = 1;
            @(posedge i_ref_clk);
        end
    endtask
    task gate(input int t, input logic v);
        @(posedge i_ref_clk) #1 o_ext_gate_n[t] = v;
    endtask
endmodule

// [dct_map.svh]
// Register offsets, field positions, reset values and timing counts for the dual counter/timer
`ifndef DCT_MAP_SVH
`define DCT_MAP_SVH

// ****************************************
// Special function register offsets
// ****************************************
`define DCT_OFF_CTRL 8'h88
`define DCT_OFF_MODE 8'h89
`define DCT_OFF_T0_LOW 8'h8A
`define DCT_OFF_T1_LOW 8'h8B
`define DCT_OFF_T0_HIGH 8'h8C
`define DCT_OFF_T1_HIGH 8'h8D
`define DCT_OFF_PRESCALE 8'h8E

// ****************************************
// Field positions
// ****************************************
`define DCT_BIT_T0_FAST 3
`define DCT_BIT_T1_FAST 4
`define DCT_BIT_T0_RUN 4
`define DCT_BIT_T0_OVF 5
`define DCT_BIT_T1_RUN 6
`define DCT_BIT_T1_OVF 7
`define DCT_PRESCALE_WMASK 8'h78

// ****************************************
// Reset values and timing
// ****************************************
`define DCT_RST_BYTE 8'h00
`define DCT_TICK_DIV 12
`define DCT_TICK_LAST 4'hB
`define DCT_MODE_13BIT 2'h0
`define DCT_MODE_16BIT 2'h1

`endif

// [dct_pkg.sv]
// Types shared by the dual counter/timer files
package dct_pkg;
    // One timer's configuration, taken from the control, mode and prescale registers
    typedef struct packed {
        logic run;
        logic gate_en;
        logic count_sel;
        logic fast_tick;
        logic [1:0] mode_sel;
    } dct_cfg_t;

    // Register access strobe group
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dct_sfr_t;

    // Edge detector states
    typedef enum logic [2:0] {
        DCT_EDGE_IDLE = 3'b001,
        DCT_EDGE_HIGH = 3'b010,
        DCT_EDGE_LOW = 3'b100
    } dct_edge_t;
endpackage

// [dct_timer.sv]
// Dual 13/16-bit counter/timer with its special function registers
`timescale 1ns/1ps
`include "dct_map.svh"
module dct_timer (
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    input wire dct_pkg::dct_sfr_t i_sfr,
    input wire logic [1:0] i_irq_ack,
    input wire logic [1:0] i_event_pin,
    input wire logic [1:0] i_ext_gate_n,
    output logic [7:0] o_rdata,
    output logic [1:0] o_irq
);
    import dct_pkg::*;

    logic [7:0] ctrl_reg;
    logic [7:0] mode_reg;
    logic [7:0] prescale_reg;
    logic [15:0] cnt_reg [2];
    logic [15:0] cnt_next [2];
    logic [3:0] div_reg;
    logic div_tick;
    logic [1:0] fall;
    logic [1:0] inc;
    logic [1:0] ovf;
    logic [1:0] wr_low;
    logic [1:0] wr_high;
    logic [7:0] rdata_next;
    dct_cfg_t cfg [2];

    // Next count value; mode 13 keeps low bits 7..5 frozen
    function automatic logic [16:0] dct_step(input logic [15:0] cnt, input logic [1:0] mode);
        logic [16:0] res;
        logic [13:0] low13;
        res = {1'b0, cnt};
        low13 = {1'b0, cnt[15:8], cnt[4:0]} + 14'h0001;
        if (mode == `DCT_MODE_13BIT) begin
            res = {low13[13], low13[12:5], cnt[7:5], low13[4:0]};
        end else if (mode == `DCT_MODE_16BIT) begin
            res = {1'b0, cnt} + 17'h00001;
        end
        return res;
    endfunction

    // Address match for one strobe; shared by every register write decode
    function automatic logic dct_hit(input logic strobe, input logic [7:0] addr, input logic [7:0] off);
        return strobe && (addr == off);
    endfunction

    // ****************************************
    // Divide by twelve tick
    // ****************************************
    // Shared divider keeps both slow timers in step
    // Free running, so a slow timer's first tick lands anywhere in twelve clocks
    assign div_tick = (div_reg == `DCT_TICK_LAST);
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            div_reg <= 4'h0;
        end else begin
            div_reg <= div_tick ? 4'h0 : div_reg + 4'h1;
        end
    end

    // ****************************************
    // Per-timer configuration and increment
    // ****************************************
    // Field slices from control, mode and prescale registers
    assign cfg[0] = '{run: ctrl_reg[`DCT_BIT_T0_RUN], gate_en: mode_reg[3], count_sel: mode_reg[2],
                      fast_tick: prescale_reg[`DCT_BIT_T0_FAST], mode_sel: mode_reg[1:0]};
    assign cfg[1] = '{run: ctrl_reg[`DCT_BIT_T1_RUN], gate_en: mode_reg[7], count_sel: mode_reg[6],
                      fast_tick: prescale_reg[`DCT_BIT_T1_FAST], mode_sel: mode_reg[5:4]};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_tmr
            logic enable;
            logic src;
            logic [16:0] step;
            logic wr_any;
            dct_edge_det u_edge (
                .i_ref_clk(i_ref_clk),
                .i_arst_n(i_arst_n),
                .i_pin(i_event_pin[g]),
                .o_fall(fall[g])
            );
            assign enable = cfg[g].run && (!cfg[g].gate_en || i_ext_gate_n[g]);
            assign src = cfg[g].count_sel ? fall[g]
                       : (cfg[g].fast_tick || div_tick);
            assign step = dct_step(cnt_reg[g], cfg[g].mode_sel);
            // Modes 2 and 3 are not built here, so they hold
            assign inc[g] = enable && src && !cfg[g].mode_sel[1];
            // Byte write strobes for this timer's count
            assign wr_low[g] = dct_hit(i_sfr.wr, i_sfr.addr, g == 0 ? `DCT_OFF_T0_LOW : `DCT_OFF_T1_LOW);
            assign wr_high[g] = dct_hit(i_sfr.wr, i_sfr.addr, g == 0 ? `DCT_OFF_T0_HIGH : `DCT_OFF_T1_HIGH);
            assign wr_any = wr_low[g] || wr_high[g];
            // Byte writes beat a same-cycle tick; run bit never touches count
            // Dropping that tick keeps a loaded start value exact
            assign cnt_next[g] = wr_any
                ? {wr_high[g] ? i_sfr.wdata : cnt_reg[g][15:8],
                   wr_low[g] ? i_sfr.wdata : cnt_reg[g][7:0]}
                : (inc[g] ? step[15:0] : cnt_reg[g]);
            // No overflow from a cycle that loads the count
            assign ovf[g] = inc[g] && !wr_any && step[16];

            always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    cnt_reg[g] <= {`DCT_RST_BYTE, `DCT_RST_BYTE};
                end else begin
                    cnt_reg[g] <= cnt_next[g];
                end
            end
        end
    endgenerate

    // ****************************************
    // Register writes
    // ****************************************
    logic [7:0] ctrl_wr;
    logic [7:0] ctrl_next;
    logic wr_ctrl;
    logic wr_mode;
    logic wr_prescale;

    // Named write decodes keep the register processes short
    assign wr_ctrl = dct_hit(i_sfr.wr, i_sfr.addr, `DCT_OFF_CTRL);
    assign wr_mode = dct_hit(i_sfr.wr, i_sfr.addr, `DCT_OFF_MODE);
    assign wr_prescale = dct_hit(i_sfr.wr, i_sfr.addr, `DCT_OFF_PRESCALE);

    // Overflow set wins over a software clear or an interrupt acknowledge
    // A clear racing a wrap would otherwise lose that overflow for good
    assign ctrl_wr = wr_ctrl ? i_sfr.wdata : ctrl_reg;
    always_comb begin
        ctrl_next = ctrl_wr;
        ctrl_next[`DCT_BIT_T0_OVF] = ovf[0] || (ctrl_wr[`DCT_BIT_T0_OVF] && !i_irq_ack[0]);
        ctrl_next[`DCT_BIT_T1_OVF] = ovf[1] || (ctrl_wr[`DCT_BIT_T1_OVF] && !i_irq_ack[1]);
    end

    // Control byte, flags already merged
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl_reg <= `DCT_RST_BYTE;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // Mode byte is plain storage for both timers
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            mode_reg <= `DCT_RST_BYTE;
        end else if (wr_mode) begin
            mode_reg <= i_sfr.wdata;
        end
    end

    // Prescale byte; bits 7 and 2..0 never stored, so they read zero
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            prescale_reg <= `DCT_RST_BYTE;
        end else if (wr_prescale) begin
            prescale_reg <= i_sfr.wdata & `DCT_PRESCALE_WMASK;
        end
    end

    // ****************************************
    // Read data and interrupt requests
    // ****************************************
    // Registered read mux; unmapped offsets read zero
    always_comb begin
        case (i_sfr.addr)
            `DCT_OFF_CTRL: rdata_next = ctrl_reg;
            `DCT_OFF_MODE: rdata_next = mode_reg;
            `DCT_OFF_T0_LOW: rdata_next = cnt_reg[0][7:0];
            `DCT_OFF_T1_LOW: rdata_next = cnt_reg[1][7:0];
            `DCT_OFF_T0_HIGH: rdata_next = cnt_reg[0][15:8];
            `DCT_OFF_T1_HIGH: rdata_next = cnt_reg[1][15:8];
            `DCT_OFF_PRESCALE: rdata_next = prescale_reg;
            default: rdata_next = 8'h00;
        endcase
    end

    // Read data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= i_sfr.rd ? rdata_next : 8'h00;
        end
    end

    // Request mirrors the flag in the same edge that sets it
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_irq <= 2'h0;
        end else begin
            o_irq <= {ctrl_next[`DCT_BIT_T1_OVF], ctrl_next[`DCT_BIT_T0_OVF]};
        end
    end
endmodule

// [dct_timer_asserts.sv]
// Port-level checks for the dual counter/timer
`timescale 1ns/1ps
module dct_timer_asserts (
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    input wire dct_pkg::dct_sfr_t i_sfr,
    input wire logic [1:0] i_irq_ack,
    input wire logic [7:0] o_rdata,
    input wire logic [1:0] o_irq
);
    import dct_pkg::*;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);
    // Strobes at one address; a write then a read two cycles on
    sequence s_wr(a);
        i_sfr.wr && i_sfr.addr == a;
    endsequence
    sequence s_rd(a);
        i_sfr.rd && i_sfr.addr == a;
    endsequence
    wire ctl_wr = i_sfr.wr && i_sfr.addr == 8'h88;
    a_rdata_idle_zero: assert property (!i_sfr.rd |=> o_rdata == 8'h00)
        else $error("read data not idle");
    a_unmapped_zero: assert property (i_sfr.rd && (i_sfr.addr < 8'h88 || i_sfr.addr > 8'h8E) |=> !o_rdata)
        else $error("unmapped read not zero");
    a_prescale_rsvd: assert property (s_rd(8'h8E) |=> !o_rdata[7] && !o_rdata[2:0])
        else $error("reserved bits set");
    a_prescale_mask: assert property (s_wr(8'h8E) ##1 !i_sfr.wr ##1 s_rd(8'h8E)
        |=> o_rdata == ($past(i_sfr.wdata, 3) & 8'h78)) else $error("prescale readback");
    a_mode_readback: assert property (s_wr(8'h89) ##1 !i_sfr.wr ##1 s_rd(8'h89)
        |=> o_rdata == $past(i_sfr.wdata, 3)) else $error("mode readback");
    a_flag_readback: assert property (s_rd(8'h88) |=> o_rdata[5] == $past(o_irq[0]))
        else $error("flag readback");
    a_flag0_holds: assert property (o_irq[0] && !i_irq_ack[0] && !ctl_wr |=> o_irq[0])
        else $error("flag 0 dropped");
    a_flag1_holds: assert property (o_irq[1] && !i_irq_ack[1] && !ctl_wr |=> o_irq[1])
        else $error("flag 1 dropped");
endmodule
bind dct_timer dct_timer_asserts u_dct_timer_asserts (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
    .i_sfr(i_sfr), .i_irq_ack(i_irq_ack), .o_rdata(o_rdata), .o_irq(o_irq));

// [tb_dual_counter_timer_13_16bit.sv]
// Self-checking bench for the dual counter/timer
`timescale 1ns/1ps
module tb_dual_counter_timer_13_16bit;
    import dct_pkg::*;
    logic clk = 0;
    logic rst_n = 0;
    dct_sfr_t sfr = '0;
    logic [1:0] ack = 0;
    wire [1:0] ev, gn;
    wire [7:0] rdata;
    wire [1:0] irq;
    logic [7:0] lo, hi;
    logic [15:0] v;
    int m, cyc = 0, err_count = 0, cmp_count = 0;
    always #25 clk = ~clk;
    dct_timer u_dct_timer (.i_ref_clk(clk), .i_arst_n(rst_n), .i_sfr(sfr), .i_irq_ack(ack),
        .i_event_pin(ev), .i_ext_gate_n(gn), .o_rdata(rdata), .o_irq(irq));
    dct_event_src u_dct_event_src (.i_ref_clk(clk), .o_event_pin(ev), .o_ext_gate_n(gn));
    task chk(input logic [7:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, d);
        @(posedge clk) #1 sfr = '{1'b1, 1'b0, a, d};
        @(posedge clk) #1 sfr.wr = 0;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk) #1 sfr = '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk) #1 sfr.rd = 0;
        d = rdata;
    endtask
    // Expected count after n ticks; modes 2 and 3 hold here
    function logic [15:0] nxt(logic [1:0] md, logic [15:0] v, int n);
        logic [12:0] s;
        s = {v[15:8], v[4:0]} + 13'(n);
        if (md == 2'h0) return {s[12:5], v[7:5], s[4:0]};
        if (md == 2'h1) return v + 16'(n);
        return v;
    endfunction
    // c is {gate, count_sel, fast, mode}; run k cycles, n ticks, f flag, a ack
    task tst(input int t, input logic [4:0] c, input logic [15:0] v, input int k, n, input logic f, a);
        logic [7:0] p;
        logic [15:0] e;
        p = 8'h80 | (8'(c[2]) << (3 + t));
        wr(8'h8E, p);
        rd(8'h8E, lo);
        chk(lo, p & 8'h78);
        wr(8'h89, 8'({c[4:3], c[1:0]}) << (4 * t));
        wr(8'(8'h8C + t), v[15:8]);
        wr(8'(8'h8A + t), v[7:0]);
        wr(8'h88, 8'h10 << (2 * t));
        if (c[3]) fork u_dct_event_src.pulses(t, n); join_none
        repeat (k) @(posedge clk);
        #1 chk(8'(irq[t]), 8'(f));
        if (a) begin
            @(posedge clk) #1 ack[t] = 1;
            @(posedge clk) #1 ack[t] = 0;
            chk(8'(irq[t]), 8'h00);
        end
        wr(8'h88, 8'h00);
        chk(8'(irq[t]), 8'h00);
        e = nxt(c[1:0], v, n);
        rd(8'(8'h8A + t), lo);
        rd(8'(8'h8C + t), hi);
        chk(lo & (c[1:0] ? 8'hFF : 8'h1F), e[7:0] & (c[1:0] ? 8'hFF : 8'h1F));
        chk(hi, e[15:8]);
        $display("test done timer %0d cfg %h", t, c);
    endtask
    task results;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            results;
        end
    end
    initial begin
        void'($urandom(32'h5cedf820));
        repeat (5) @(posedge clk);
        #1 rst_n = 1;
        for (int a = 8'h87; a <= 8'h8F; a++) begin
            rd(8'(a), lo);
            chk(lo, 8'h00);
        end
        for (int t = 0; t < 2; t++) begin
            // Wraps: 16-bit cleared by ack, 13-bit by software
            v = 16'hFFFF - 16'($urandom % 30);
            tst(t, 5'b00101, v, 40, 44, 1, 1);
            v = {8'hFF, 3'($urandom), 5'h1F - 5'($urandom % 20)};
            tst(t, 5'b00100, v, 40, 42, 1, 0);
            // Twelve clocks a tick when slow
            m = 1 + $urandom % 6;
            tst(t, 5'b00001, 16'($urandom % 32'hF000), 12 * m - 2, m, 0, 0);
            v = 16'($urandom % 32'hF000);
            u_dct_event_src.gate(t, 0);
            tst(t, 5'b10101, v, 20, 0, 0, 0);
            u_dct_event_src.gate(t, 1);
            tst(t, 5'b10101, v, 20, 22, 0, 0);
            m = 1 + $urandom % 8;
            tst(t, 5'b01101, v, 4 * m + 8, m, 0, 0);
            tst(t, 5'b00110, v, 20, 0, 0, 0);
            tst(t, 5'b00111, v, 20, 0, 0, 0);
        end
        results;
    end
endmodule
